// File: hdl/lfc_bank.sv
/*
  Register bank holding the string fault configuration register and the
  supply interrupt enable register, with the control outputs they steer.
  Assumes the serial register interface delivers one-cycle read and write
  requests synchronous to mclk_in; read data follows one cycle later.
  Assumes wr and rd are never raised together in one request; offsets other
  than the two registers ignore writes and read back zero.
  Assumes the raw short faults are levels already synchronous to mclk_in.
*/
// Contract
// - Ground-short detection of LED outputs runs in soft-start and normal operation only while bit 8 is set.
// - Mask bit n-1 set suppresses the internal short fault of string n; clear leaves it enabled.
// - Each two-bit interrupt enable field reads 0h when disabled and 2h when enabled.
// - Writing 1h into an enable field disables its interrupt and 3h enables it.
// - The supply interrupt enable register sits at 08h, resets to 2AAAh, bits 15-14 read zero.
// - Bits 13-12 gate the missing boost sync clock interrupt, reset enabled.
// - Bits 11-10 gate the charge pump fault interrupt, reset enabled.
// - Bits 9-8 gate the missing charge pump capacitor interrupt, reset enabled.
// - Bits 7-6, 5-4, 3-2, 1-0 gate input over-current, VDD under-voltage, input over- and under-voltage.
// - The string fault configuration register sits at 06h and resets to 100h.
`timescale 1ns/1ps
module lfc_bank
  import lfc_pkg::*;
(
  input  wire logic                        mclk_in,
  input  wire logic                        nrst_in,
  input  wire lfc_req_type                 req_in,
  input  wire logic [LFC_STRING_COUNT-1:0] short_fault_raw_in,
  output logic [15:0]                      rdata_out,
  output logic                             rvalid_out,
  output logic                             ground_short_detect_enable_out,
  output logic [LFC_STRING_COUNT-1:0]      short_fault_out,
  output lfc_supply_en_type                supply_en_out
);

  // Decoding used by both registers
  function automatic logic hit(input lfc_req_type r, input logic [7:0] off);
    hit = (r.addr == off);
  endfunction

  // Next state of one keyed gate: only the two keys move it, 0h and 2h keep it.
  // Mirrors the field module so the registered output gate turns with its field.
  function automatic logic keyed_next(input logic cur, input logic wr, input logic [1:0] key);
    keyed_next = cur;
    if (wr && key == LFC_KEY_DISABLE) begin
      keyed_next = 1'b0;
    end else if (wr && key == LFC_KEY_ENABLE) begin
      keyed_next = 1'b1;
    end
  endfunction

  // Gate reset image: the upper (enabled) bit of every field of the supply reset word
  function automatic logic [LFC_SUPPLY_FIELDS-1:0] odd_bits(input logic [15:0] word);
    odd_bits = '0;
    for (int f = 0; f < LFC_SUPPLY_FIELDS; f++) begin
      odd_bits[f] = word[2*f+1];
    end
  endfunction

  // Derived once so the output gates and the field flops can never disagree at reset
  localparam logic [LFC_SUPPLY_FIELDS-1:0] SUP_RESET_GATES = odd_bits(LFC_SUPPLY_IRQ_ENABLES_RESET);

  // String fault configuration word and the controls it steers
  logic [15:0]                  cfg_reg;
  logic [15:0]                  cfg_next;
  logic                         gnd_en_reg;
  logic                         gnd_en_next;
  logic [LFC_STRING_COUNT-1:0]  fault_reg;
  logic [LFC_STRING_COUNT-1:0]  fault_next;

  // Read return path
  logic [15:0]                  rdata_reg;
  logic [15:0]                  rdata_next;
  logic                         rvalid_reg;
  logic                         rvalid_next;

  // Supply interrupt gates: keyed fields, their read image and the output copy
  lfc_supply_en_type            sup_reg;
  lfc_supply_en_type            sup_next;
  logic [LFC_SUPPLY_FIELDS-1:0] sup_next_bits;
  logic                         sup_wr;
  logic [LFC_SUPPLY_FIELDS-1:0] sup_en;
  logic [15:0]                  sup_rd;

  assign sup_wr = req_in.wr && hit(req_in, LFC_SUPPLY_IRQ_ENABLES_OFFSET);

  // One keyed field per supply source; field 6 is bits 13-12 down to field 0 at bits 1-0
  genvar k;
  generate
    for (k = 0; k < LFC_SUPPLY_FIELDS; k++) begin : g_field
      lfc_keyed_enable #(
        .RESET_ENABLED (LFC_SUPPLY_IRQ_ENABLES_RESET[2*k+1])
      ) u_field (
        .mclk_in (mclk_in),
        .nrst_in (nrst_in),
        .wr_in   (sup_wr),
        .key_in  (req_in.wdata[2*k+1:2*k]),
        .en_out  (sup_en[k]),
        .rd_out  (sup_rd[2*k+1:2*k])
      );
    end
  endgenerate

  // Reserved top bits of the supply register have no storage and read zero
  assign sup_rd[15:LFC_SUPPLY_RSVD_LSB] = 2'h0;

  // String fault configuration: plain read/write storage of all 16 bits.
  // Bits 7-6 are stored as written; the host keeps them zero, so no clamp here.
  always_comb begin
    cfg_next = cfg_reg;
    if (req_in.wr && hit(req_in, LFC_STRING_FAULT_CONFIG_OFFSET)) begin
      cfg_next = req_in.wdata;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_reg <= LFC_STRING_FAULT_CONFIG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Read path: registered data one cycle after the read request
  always_comb begin
    rvalid_next = req_in.rd;
    rdata_next  = 16'h0000; // Unmapped offsets read zero
    if (req_in.rd && hit(req_in, LFC_STRING_FAULT_CONFIG_OFFSET)) begin
      rdata_next = cfg_reg;
    end else if (req_in.rd && hit(req_in, LFC_SUPPLY_IRQ_ENABLES_OFFSET)) begin
      rdata_next = sup_rd;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Control outputs registered from the next register state so they track a write
  // in the same edge the register updates, and outputs come straight from flops.
  // The gates use the keyed next state; the stored field state would lag a cycle.
  always_comb begin
    gnd_en_next   = cfg_next[LFC_GND_DETECT_BIT];
    fault_next    = short_fault_raw_in & ~cfg_next[LFC_MASK_LSB +: LFC_STRING_COUNT];
    sup_next_bits = '0;
    for (int f = 0; f < LFC_SUPPLY_FIELDS; f++) begin
      sup_next_bits[f] = keyed_next(sup_en[f], sup_wr, req_in.wdata[2*f +: 2]);
    end
    // Sources named one by one so a reordered struct cannot swap them silently
    sup_next.sync_clock_missing_irq_enable        = sup_next_bits[6];
    sup_next.charge_pump_irq_enable               = sup_next_bits[5];
    sup_next.pump_capacitor_missing_irq_enable    = sup_next_bits[4];
    sup_next.input_overcurrent_irq_enable         = sup_next_bits[3];
    sup_next.logic_supply_undervoltage_irq_enable = sup_next_bits[2];
    sup_next.input_overvoltage_irq_enable         = sup_next_bits[1];
    sup_next.input_undervoltage_irq_enable        = sup_next_bits[0];
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gnd_en_reg <= LFC_STRING_FAULT_CONFIG_RESET[LFC_GND_DETECT_BIT];
      fault_reg  <= '0;
      sup_reg    <= SUP_RESET_GATES;
    end else begin
      gnd_en_reg <= gnd_en_next;
      fault_reg  <= fault_next;
      sup_reg    <= sup_next;
    end
  end

  assign rdata_out                      = rdata_reg;
  assign rvalid_out                     = rvalid_reg;
  assign ground_short_detect_enable_out = gnd_en_reg;
  assign short_fault_out                = fault_reg;
  assign supply_en_out                  = sup_reg;

endmodule

// File: hdl/lfc_pkg.sv
/*
  Package for the LED fault configuration and supply interrupt enable bank:
  register offsets, field positions, reset values and the carrier structs.
  Assumes a 16-bit register path from the serial register interface logic.
*/
package lfc_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0]  LFC_STRING_FAULT_CONFIG_OFFSET = 8'h06;
  localparam logic [7:0]  LFC_SUPPLY_IRQ_ENABLES_OFFSET  = 8'h08;

  // Reset values
  localparam logic [15:0] LFC_STRING_FAULT_CONFIG_RESET  = 16'h0100;
  localparam logic [15:0] LFC_SUPPLY_IRQ_ENABLES_RESET   = 16'h2aaa;

  // String fault configuration field positions
  localparam int          LFC_GND_DETECT_BIT             = 8;
  localparam int          LFC_MASK_LSB                   = 0;
  localparam int          LFC_STRING_COUNT               = 6;
  localparam int          LFC_KEEP_ZERO_MSB              = 7;
  localparam int          LFC_KEEP_ZERO_LSB              = 6;

  // Supply enable fields: field k occupies bits 2k+1..2k
  localparam int          LFC_SUPPLY_FIELDS              = 7;
  localparam int          LFC_SUPPLY_RSVD_LSB            = 14;

  // Keyed field codes
  localparam logic [1:0]  LFC_KEY_DISABLE                = 2'h1;
  localparam logic [1:0]  LFC_KEY_ENABLE                 = 2'h3;
  localparam logic [1:0]  LFC_READ_ENABLED               = 2'h2;
  localparam logic [1:0]  LFC_READ_DISABLED              = 2'h0;

  // Register access request from the serial interface logic
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } lfc_req_type;

  // Supply interrupt gates toward the interrupt logic
  typedef struct packed {
    logic sync_clock_missing_irq_enable;
    logic charge_pump_irq_enable;
    logic pump_capacitor_missing_irq_enable;
    logic input_overcurrent_irq_enable;
    logic logic_supply_undervoltage_irq_enable;
    logic input_overvoltage_irq_enable;
    logic input_undervoltage_irq_enable;
  } lfc_supply_en_type;

endpackage

// File: hdl/lfc_keyed_enable.sv
/*
  One keyed two-bit interrupt enable field: a stored enable bit that changes
  only on the disable or enable key, and reads back as 0h or 2h.
  Assumes wr_in is a one-cycle write strobe already decoded for the register.
*/
`timescale 1ns/1ps
module lfc_keyed_enable
  import lfc_pkg::*;
#(
  parameter logic RESET_ENABLED = 1'b1
) (
  input  wire logic       mclk_in,
  input  wire logic       nrst_in,
  input  wire logic       wr_in,
  input  wire logic [1:0] key_in,
  output logic            en_out,
  output logic [1:0]      rd_out
);

  logic en_reg;
  logic en_next;

  // Only the two keys move the state; 0h and 2h keep it so a whole-word write is safe
  always_comb begin
    en_next = en_reg;
    if (wr_in && key_in == LFC_KEY_DISABLE) begin
      en_next = 1'b0;
    end else if (wr_in && key_in == LFC_KEY_ENABLE) begin
      en_next = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_reg <= RESET_ENABLED;
    end else begin
      en_reg <= en_next;
    end
  end

  assign en_out = en_reg;
  assign rd_out = en_reg ? LFC_READ_ENABLED : LFC_READ_DISABLED;

endmodule

// File: dv/lfc_bank_chk.sv
/* Port checker for the fault config and supply enable bank.
   Assumes it is bound to lfc_bank. */
`timescale 1ns/1ps
module lfc_bank_chk
  import lfc_pkg::*;
(
  input wire logic              mclk_in,
  input wire logic              nrst_in,
  input wire lfc_req_type       req_in,
  input wire logic [5:0]        short_fault_raw_in,
  input wire logic [15:0]       rdata_out,
  input wire logic              rvalid_out,
  input wire logic              ground_short_detect_enable_out,
  input wire logic [5:0]        short_fault_out,
  input wire lfc_supply_en_type supply_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Decoded write strobes
  wire w6 = req_in.wr && req_in.addr == 8'h06;
  wire w8 = req_in.wr && req_in.addr == 8'h08;
  property p_gnd; w6 |=> ground_short_detect_enable_out == $past(req_in.wdata[8]); endproperty
  a_gnd: assert property (p_gnd) else $error("ground enable wrong");
  // Checked two cycles on; a registered fault already clears at the write edge
  property p_msk; w6 && req_in.wdata[5:0] == 6'h3f ##1 !w6 |=> short_fault_out == 6'h0; endproperty
  a_msk: assert property (p_msk) else $error("masked fault seen");
  property p_dis; w8 && req_in.wdata[1:0] == 2'h1 |=> !supply_en_out.input_undervoltage_irq_enable; endproperty
  a_dis: assert property (p_dis) else $error("disable key ignored");
  property p_en8; w8 && req_in.wdata[13:12] == 2'h3 |=> supply_en_out.sync_clock_missing_irq_enable; endproperty
  a_en8: assert property (p_en8) else $error("enable key ignored");
  property p_keep; w8 && !req_in.wdata[10] |=> $stable(supply_en_out.charge_pump_irq_enable); endproperty
  a_keep: assert property (p_keep) else $error("keep key changed state");
  property p_cap; w8 && req_in.wdata[9:8] == 2'h1 |=> !supply_en_out.pump_capacitor_missing_irq_enable; endproperty
  a_cap: assert property (p_cap) else $error("cap disable ignored");
  property p_oc; w8 && req_in.wdata[7:6] == 2'h3 |=> supply_en_out.input_overcurrent_irq_enable; endproperty
  a_oc: assert property (p_oc) else $error("overcurrent enable ignored");
  property p_rd8; req_in.rd && req_in.addr == 8'h08 |=> rvalid_out && (rdata_out & 16'hd555) == 16'h0; endproperty
  a_rd8: assert property (p_rd8) else $error("supply read image wrong");
endmodule

// File: dv/lfc_host_model.sv
/* Host model issuing one register request per call.
   Assumes the bank takes a request at each rising edge. */
`timescale 1ns/1ps
module lfc_host_model
  import lfc_pkg::*;
(
  input  wire logic  mclk_in,
  output lfc_req_type req_out
);
  initial req_out = '0;
  // Driven at falling edges; released lines show inverted values, not stale ones
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    req_out = '{w, !w, a, (a == 8'h06) ? (d & 16'hff3f) : d};
    @(negedge mclk_in);
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

// File: dv/tb_top.sv
/* Self-checking bench for the bank with random and corner traffic.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
  import lfc_pkg::*;
  logic              mclk_in = 1'b0;
  logic              nrst_in = 1'b0;
  logic [5:0]        short_fault_raw_in = 6'h0;
  lfc_req_type       req_in;
  logic [15:0]       rdata_out;
  logic              rvalid_out;
  logic              ground_short_detect_enable_out;
  logic [5:0]        short_fault_out;
  lfc_supply_en_type supply_en_out;
  logic [15:0]       cfg = 16'h0100;
  logic [15:0]       rnd = 16'h1d9b;
  logic [6:0]        en = 7'h7f;
  int                n_mismatch = 0;
  int                num_checks = 0;
  always #4 mclk_in = ~mclk_in;
  lfc_host_model u_host(.mclk_in(mclk_in), .req_out(req_in));
  lfc_bank DUT(.*);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Read image: an enabled field shows 2h
  function automatic logic [15:0] img(input logic [6:0] e);
    img = 16'h0;
    for (int k = 0; k < 7; k++) img[2*k+1] = e[k];
  endfunction
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Control outputs against the model; mask and gates turn at the taking edge
  task automatic ctl(input bit sf);
    chk("gnd", {15'h0, cfg[8]}, {15'h0, ground_short_detect_enable_out});
    chk("sup_en", {9'h0, en}, {9'h0, supply_en_out});
    if (sf) chk("sf", {10'h0, short_fault_raw_in & ~cfg[5:0]}, {10'h0, short_fault_out});
  endtask
  // Key bit 0 set means update, key bit 1 carries the new state
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_host.access(1'b1, a, d);
    if (a == 8'h06) cfg = d & 16'hff3f;
    if (a == 8'h08) for (int k = 0; k < 7; k++) if (d[2*k]) en[k] = d[2*k+1];
    ctl(1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex);
    u_host.access(1'b0, a, 16'h0);
    chk("rvalid", 16'h1, {15'h0, rvalid_out});
    chk("rdata", ex, rdata_out);
  endtask
  initial begin
    repeat (12) @(negedge mclk_in);
    ctl(1'b1);
    nrst_in = 1'b1;
    rd(8'h06, 16'h0100);
    rd(8'h08, img(en));
    for (int k = 0; k < 7; k++)
      for (int c = 0; c < 4; c++) begin
        wr(8'h08, 16'(c << (2 * k)));
        rd(8'h08, img(en));
      end
    // All strings masked under full raw faults, then an unmapped place
    short_fault_raw_in = 6'h3f;
    wr(8'h06, 16'h003f);
    wr(8'h0a, 16'hffff);
    rd(8'h0a, 16'h0);
    for (int i = 0; i < 40; i++) begin
      rnd = lfsr(rnd);
      short_fault_raw_in = rnd[5:0];
      wr(8'h06, rnd ^ 16'h5a00);
      rnd = lfsr(rnd);
      wr(8'h08, rnd);
      rd(8'h06, cfg);
      rd(8'h08, img(en));
    end
    give_verdict();
  end
endmodule
bind lfc_bank lfc_bank_chk u_chk(.*);
